/* design/wake_params.svh */
// Offsets, field positions, reset values and timing for the wake controller
// Assumes a 100 MHz always-on clock and a 32-bit AXI4-Lite register bus
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH

// Register byte offsets
`define OFF_CTRL 4'h0
`define OFF_CONFIG 4'h4
`define OFF_STATUS 4'h8
`define OFF_FLAGS 4'hC

// CTRL fields (write strobes)
`define CTRL_SLEEP 0
`define CTRL_TGT_LO 1
`define CTRL_TGT_HI 2
`define CTRL_DEEP 3
`define CTRL_HARD_RST 4

// Wake source bit positions, in CONFIG and FLAGS
`define SRC_W 6
`define SRC_BUTTON 0
`define SRC_RTC 1
`define SRC_NET 2
`define SRC_USB 3
`define SRC_PCIE 4
`define SRC_IR 5

// CONFIG fields
`define CFG_USB_S5 8
`define CFG_POL_LO 9
`define CFG_POL_HI 10
`define CONFIG_RESET 32'h0000_053F

// Sleep targets and last-state policies
`define TGT_S3 2'h0
`define TGT_S4 2'h1
`define TGT_S5 2'h2
`define POL_OFF 2'h0
`define POL_ON 2'h1
`define POL_LAST 2'h2

// Front panel reset pulse
`define CLK_PERIOD_NS 10
`define FP_RESET_NS 1000
`define FP_RESET_CYC ((`FP_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* design/wake_pkg.sv */
// Types shared by the platform wake controller
// Used with wake_params.svh, which holds the numbers
package wake_pkg;

  // Platform power states as the sequencer sees them
  typedef enum logic [2:0] {
    ST_G3,
    ST_S5,
    ST_S4,
    ST_S3,
    ST_PWRUP,
    ST_S0
  } pwr_state_t;

endpackage : wake_pkg

/* design/platform_wake_controller.sv */
// Platform wake and power-state controller on the always-on standby clock
// Assumes wake inputs synchronous to clk and an AXI4-Lite master in S0
//
// How it works
// (R01) Power button wakes from any sleep state
// (R02) AC return restores prior state per policy
// (R03) Network block asserts wake on pattern frame
// (R04) USB wakes S3, never after mechanical-off
// (R05) No USB wake in deep S4/S5
// (R06) USB S5 wake needs firmware enable bit
// (R07) PCIe wake line wakes S3, S4, S5
// (R08) RTC alarm wakes platform from S5
// (R09) Infrared remote wakes S3, S4, S5
// (R10) Infrared ignored in deep S4/S5
// (R11) Radio activity never starts a wake
// (R12) S3 LED amber, or off if single
// (R13) Front panel reset at power-up, hard reset
// (R14) Sticky clearable wake flags request power-up
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "wake_params.svh"

module platform_wake_controller #(
  parameter bit DUAL_LED = 1'b1,
  parameter int RESET_CYCLES = `FP_RESET_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  // Wake sources
  input wire logic power_button,
  input wire logic rtc_alarm,
  input wire logic network_wake,
  input wire logic usb_activity,
  input wire logic pcie_wake_n,
  input wire logic infrared_remote,
  input wire logic radio_activity,
  input wire logic ac_power_ok,
  // Power rails and indicators
  output logic rail_enable,
  output logic led_primary,
  output logic led_secondary,
  output logic front_panel_reset_n,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  wake_pkg::pwr_state_t state_reg;
  wake_pkg::pwr_state_t state_next;
  logic [31:0] config_reg;
  logic [`SRC_W-1:0] flags_reg;
  logic [`SRC_W-1:0] flags_next;
  logic [`SRC_W-1:0] qualify;
  logic deep_reg;
  logic after_g3_reg;
  logic last_on_reg;
  logic [15:0] rst_cnt_reg;
  logic rst_done;
  logic asleep;
  logic wake_req;
  logic ac_prev_reg;
  logic ac_return;
  // Write path
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic [31:0] wr_mask;
  logic sleep_cmd;
  logic hard_rst_cmd;
  logic flags_wr;
  logic [1:0] sleep_tgt;

  // Bus write: latch address and data in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response, error on unmapped or read-only offset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_reg == `OFF_CTRL || awaddr_reg == `OFF_CONFIG ||
          awaddr_reg == `OFF_FLAGS) begin
        s_axi_bresp <= `RESP_OKAY;
      end else begin
        s_axi_bresp <= `RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane mask and decoded write strobes
  assign wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                    {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign sleep_cmd = wr_fire && awaddr_reg == `OFF_CTRL && wstrb_reg[0] &&
                     wdata_reg[`CTRL_SLEEP];
  assign hard_rst_cmd = wr_fire && awaddr_reg == `OFF_CTRL && wstrb_reg[0] &&
                        wdata_reg[`CTRL_HARD_RST];
  assign flags_wr = wr_fire && awaddr_reg == `OFF_FLAGS && wstrb_reg[0];
  assign sleep_tgt = wdata_reg[`CTRL_TGT_HI:`CTRL_TGT_LO];

  // Configuration: wake enables, USB S5 enable, last-state policy
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      config_reg <= `CONFIG_RESET;
    end else if (wr_fire && awaddr_reg == `OFF_CONFIG) begin
      config_reg <= (config_reg & ~wr_mask) | (wdata_reg & wr_mask);
    end
  end

  // Sleep qualification of each wake source
  assign asleep = state_reg == wake_pkg::ST_S3 ||
                  state_reg == wake_pkg::ST_S4 ||
                  state_reg == wake_pkg::ST_S5;

  always_comb begin
    qualify = '0;
    // (R01) button wakes
    qualify[`SRC_BUTTON] = power_button;
    // (R08) RTC alarm wake
    qualify[`SRC_RTC] = rtc_alarm;
    // (R03) network wake input
    qualify[`SRC_NET] = network_wake;
    // (R07) PCIe wake line
    qualify[`SRC_PCIE] = !pcie_wake_n;
    // (R04) USB in S3, gated in S5, never in S4
    if (state_reg == wake_pkg::ST_S3) begin
      qualify[`SRC_USB] = usb_activity && !after_g3_reg;
    end else if (state_reg == wake_pkg::ST_S5) begin
      // (R05) (R06) USB S5 gated
      qualify[`SRC_USB] = usb_activity && !after_g3_reg && !deep_reg &&
                          config_reg[`CFG_USB_S5];
    end
    // (R09) (R10) infrared, not deep
    if (state_reg == wake_pkg::ST_S3) begin
      qualify[`SRC_IR] = infrared_remote;
    end else begin
      qualify[`SRC_IR] = infrared_remote && !deep_reg;
    end
    // (R11) radio never qualifies
    if (radio_activity) begin
      qualify[`SRC_BUTTON] = qualify[`SRC_BUTTON];
    end
    if (!asleep) begin
      qualify = '0;
    end
  end

  // (R14) sticky flags, set wins
  always_comb begin
    flags_next = flags_reg;
    if (flags_wr) begin
      flags_next = flags_reg & ~wdata_reg[`SRC_W-1:0];
    end
    flags_next = flags_next | (qualify & config_reg[`SRC_W-1:0]);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // (R14) any flag requests power-up
  assign wake_req = asleep && (|flags_reg);

  // AC presence edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ac_prev_reg <= 1'b0;
    end else begin
      ac_prev_reg <= ac_power_ok;
    end
  end

  assign ac_return = ac_power_ok && !ac_prev_reg;
  assign rst_done = rst_cnt_reg >= 16'(RESET_CYCLES - 1);

  // Power state sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wake_pkg::ST_G3: begin
        // (R02) restore per policy
        if (ac_return) begin
          if (config_reg[`CFG_POL_HI:`CFG_POL_LO] == `POL_ON ||
              (config_reg[`CFG_POL_HI:`CFG_POL_LO] == `POL_LAST && last_on_reg)) begin
            state_next = wake_pkg::ST_PWRUP;
          end else begin
            state_next = wake_pkg::ST_S5;
          end
        end
      end
      wake_pkg::ST_S3, wake_pkg::ST_S4, wake_pkg::ST_S5: begin
        if (wake_req) begin
          state_next = wake_pkg::ST_PWRUP;
        end
      end
      wake_pkg::ST_PWRUP: begin
        if (rst_done) begin
          state_next = wake_pkg::ST_S0;
        end
      end
      wake_pkg::ST_S0: begin
        if (hard_rst_cmd) begin
          state_next = wake_pkg::ST_PWRUP;
        end else if (sleep_cmd) begin
          case (sleep_tgt)
            `TGT_S3: state_next = wake_pkg::ST_S3;
            `TGT_S4: state_next = wake_pkg::ST_S4;
            default: state_next = wake_pkg::ST_S5;
          endcase
        end
      end
      default: state_next = wake_pkg::ST_G3;
    endcase
    if (!ac_power_ok) begin
      state_next = wake_pkg::ST_G3;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= wake_pkg::ST_G3;
    end else begin
      state_reg <= state_next;
    end
  end

  // Deep-sleep flag taken with the sleep command
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      deep_reg <= 1'b0;
    end else if (state_reg == wake_pkg::ST_S0 && sleep_cmd) begin
      deep_reg <= wdata_reg[`CTRL_DEEP] && sleep_tgt != `TGT_S3;
    end
  end

  // (R04) mechanical-off memory until working
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      after_g3_reg <= 1'b1;
    end else if (state_reg == wake_pkg::ST_G3) begin
      after_g3_reg <= 1'b1;
    end else if (state_reg == wake_pkg::ST_S0) begin
      after_g3_reg <= 1'b0;
    end
  end

  // (R02) remember on or off
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      last_on_reg <= 1'b0;
    end else if (state_reg == wake_pkg::ST_S0) begin
      last_on_reg <= 1'b1;
    end else if (asleep) begin
      last_on_reg <= 1'b0;
    end
  end

  // (R13) reset pulse length counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_cnt_reg <= 16'h0000;
    end else if (state_reg != wake_pkg::ST_PWRUP) begin
      rst_cnt_reg <= 16'h0000;
    end else if (!rst_done) begin
      rst_cnt_reg <= rst_cnt_reg + 16'h0001;
    end
  end

  // Rails, indicators and front panel reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rail_enable <= 1'b0;
      led_primary <= 1'b0;
      led_secondary <= 1'b0;
      front_panel_reset_n <= 1'b0;
    end else begin
      rail_enable <= state_next == wake_pkg::ST_PWRUP ||
                     state_next == wake_pkg::ST_S0;
      led_primary <= state_next == wake_pkg::ST_S0;
      // (R12) amber in S3
      led_secondary <= DUAL_LED && state_next == wake_pkg::ST_S3;
      // (R13) reset during power-up
      front_panel_reset_n <= state_next == wake_pkg::ST_S0;
    end
  end

  // Bus read with registered data
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFF_CTRL: s_axi_rdata <= 32'h0000_0000;
        `OFF_CONFIG: s_axi_rdata <= config_reg;
        `OFF_STATUS: s_axi_rdata <= {26'h000_0000, deep_reg, last_on_reg,
                                     after_g3_reg, 3'(state_reg)};
        `OFF_FLAGS: s_axi_rdata <= {26'h000_0000, flags_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : platform_wake_controller

/* sim/wake_partner.sv */
// Model of the wake sources and the AC supply around the wake controller
// Assumes the bench picks one source and strobes go for one clock
`timescale 1ns/1ps
module wake_partner (
  input wire logic clk,
  input wire logic [3:0] pick,
  input wire logic go,
  input wire logic ac_on,
  output logic power_button,
  output logic rtc_alarm,
  output logic network_wake,
  output logic usb_activity,
  output logic pcie_wake_n,
  output logic infrared_remote,
  output logic radio_activity,
  output logic ac_power_ok
);
  logic [1:0] hold_cnt = 2'h0;
  logic [6:0] act = 7'h00;
  // Picked source stays active for four cycles
  always_ff @(posedge clk) begin
    if (go) begin
      act <= 7'h01 << pick;
      hold_cnt <= 2'h3;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end else begin
      act <= 7'h00;
    end
  end
  // Source levels, PCIe line active low
  assign power_button = act[0];
  assign rtc_alarm = act[1];
  assign network_wake = act[2];
  assign usb_activity = act[3];
  assign pcie_wake_n = !act[4];
  assign infrared_remote = act[5];
  assign radio_activity = act[6];
  assign ac_power_ok = ac_on;
endmodule : wake_partner

/* sim/platform_wake_controller_chk.sv */
// Port checker for the wake controller
// Assumes it is bound into every platform_wake_controller
`timescale 1ns/1ps
module wake_chk #(
  parameter int RESET_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ac_power_ok,
  input wire logic rail_enable,
  input wire logic led_primary,
  input wire logic led_secondary,
  input wire logic front_panel_reset_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rready
);
  int pwrup_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Counts cycles with rails up and front panel held
  always_ff @(posedge clk) begin
    if (!reset_n || !rail_enable || front_panel_reset_n) pwrup_cnt <= 0;
    else pwrup_cnt <= pwrup_cnt + 1;
  end
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  pwrup_len_a: assert property ($rose(front_panel_reset_n) |-> pwrup_cnt == RESET_CYCLES)
    else $error("power-up length wrong");
  fp_step_a: assert property (front_panel_reset_n == led_primary)
    else $error("front panel reset out of step");
  rail_on_a: assert property (led_primary |-> rail_enable)
    else $error("working without rails");
  amber_a: assert property (led_secondary |-> !rail_enable && !led_primary)
    else $error("amber outside S3");
  ac_off_a: assert property (!ac_power_ok |=> !rail_enable)
    else $error("rails up without AC");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  read_ans_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : wake_chk

bind platform_wake_controller wake_chk #(.RESET_CYCLES(RESET_CYCLES)) u_chk (.clk, .reset_n,
  .ac_power_ok, .rail_enable, .led_primary, .led_secondary, .front_panel_reset_n,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rready);

/* sim/platform_wake_controller_test.sv */
// Self-checking bench for the wake controller
// Assumes wake_partner drives the sources and the bench is the bus master
`timescale 1ns/1ps
`include "wake_params.svh"
module platform_wake_controller_test;
  logic clk = 0, reset_n = 0, go = 0, ac_on = 1;
  logic [3:0] pick = 0, s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic power_button, rtc_alarm, network_wake, usb_activity, pcie_wake_n;
  logic infrared_remote, radio_activity, ac_power_ok;
  logic rail_enable, led_primary, led_secondary, front_panel_reset_n;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, val;
  logic [19:0] c;
  int mismatches = 0, samples_checked = 0;
  // Config, source, target, deep and expected wake per case
  logic [19:0] cases [14] = '{20'h53F01, 20'h53F19, 20'h53F25, 20'h53F31, 20'h53F34,
    20'h53F3A, 20'h53F39, 20'h43F38, 20'h53F47, 20'h53F5A, 20'h53F55, 20'h53F60,
    20'h53B28, 20'h53F41};

  // Clock at 100 MHz
  initial forever #5 clk = ~clk;
  wake_partner u_src (.clk, .pick, .go, .ac_on, .power_button, .rtc_alarm, .network_wake,
    .usb_activity, .pcie_wake_n, .infrared_remote, .radio_activity, .ac_power_ok);
  platform_wake_controller #(.RESET_CYCLES(4)) u_dut (.clk, .reset_n, .power_button,
    .rtc_alarm, .network_wake, .usb_activity, .pcie_wake_n, .infrared_remote,
    .radio_activity, .ac_power_ok, .rail_enable, .led_primary, .led_secondary,
    .front_panel_reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  task conclude();
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk

  task timeout();
    mismatches++;
    $display("[ERR] %0t no answer", $time);
    conclude();
  endtask : timeout

  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic aw_hit, w_hit, b_hit;
    b_hit = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !b_hit; n++) begin
      @(negedge clk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid;
      if (b_hit) chk(32'(s_axi_bresp), 32'(resp));
      @(posedge clk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) s_axi_bready <= 1'b0;
    end
    if (!b_hit) timeout();
  endtask : wr

  // Read with rready raised late, then masked compare
  task rdc(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] want);
    logic ar_hit, r_hit, rv;
    r_hit = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 50 && !r_hit; n++) begin
      @(negedge clk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      r_hit = rv && s_axi_rready;
      if (r_hit) chk(s_axi_rdata & mask, want);
      if (r_hit) chk(32'(s_axi_rresp), 32'(a[1:0] == 2'h0 ? `RESP_OKAY : `RESP_SLVERR));
      @(posedge clk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (rv) s_axi_rready <= !r_hit;
    end
    if (!r_hit) timeout();
  endtask : rdc

  task pulse(input logic [3:0] p);
    repeat ($urandom_range(3)) @(posedge clk);
    @(posedge clk);
    pick <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse

  task woke(input logic want);
    logic seen;
    seen = 0;
    for (int n = 0; n < 40 && !seen; n++) begin
      @(negedge clk);
      seen = front_panel_reset_n;
    end
    chk(32'(seen), 32'(want));
  endtask : woke

  task ac_cycle();
    @(posedge clk);
    ac_on <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(32'(rail_enable), 32'h0);
    @(posedge clk);
    ac_on <= 1'b1;
  endtask : ac_cycle

  // Main sequence
  initial begin
    void'($urandom(32'h65AC));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(`OFF_CONFIG, 32'hFFFF_FFFF, `CONFIG_RESET);
    rdc(`OFF_STATUS, 32'hF, 32'h9);
    pulse(4'h0);
    woke(1'b1);
    chk(32'(led_primary), 32'h1);
    rdc(`OFF_STATUS, 32'h7, 32'h5);
    val = $urandom & 32'h0000_073F;
    wr(`OFF_CONFIG, val, `RESP_OKAY);
    rdc(`OFF_CONFIG, 32'hFFFF_FFFF, val);
    wr(`OFF_STATUS, 32'h0, `RESP_SLVERR);
    rdc(4'h6, 32'hFFFF_FFFF, 32'h0);
    foreach (cases[i]) begin
      c = cases[i];
      wr(`OFF_CONFIG, 32'(c[19:8]), `RESP_OKAY);
      wr(`OFF_FLAGS, 32'h3F, `RESP_OKAY);
      wr(`OFF_CTRL, 32'({c[1], c[3:2], 1'b1}), `RESP_OKAY);
      rdc(`OFF_STATUS, 32'h7, 32'(3 - c[3:2]));
      chk(32'(led_secondary), 32'(c[3:2] == 2'h0));
      pulse(c[7:4]);
      woke(c[0]);
      rdc(`OFF_FLAGS, 32'h3F, c[0] ? 32'h1 << c[7:4] : 32'h0);
      if (!c[0]) pulse(4'h0);
      woke(1'b1);
    end
    wr(`OFF_CTRL, 32'h11, `RESP_OKAY);
    @(negedge clk);
    chk(32'(front_panel_reset_n), 32'h0);
    woke(1'b1);
    wr(`OFF_CONFIG, 32'h53F, `RESP_OKAY);
    ac_cycle();
    woke(1'b1);
    wr(`OFF_FLAGS, 32'h3F, `RESP_OKAY);
    wr(`OFF_CONFIG, 32'h13F, `RESP_OKAY);
    ac_cycle();
    repeat (5) @(posedge clk);
    rdc(`OFF_STATUS, 32'hF, 32'h9);
    pulse(4'h3);
    woke(1'b0);
    wr(`OFF_CONFIG, 32'h33F, `RESP_OKAY);
    ac_cycle();
    woke(1'b1);
    wr(`OFF_FLAGS, 32'h3F, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h5, `RESP_OKAY);
    rdc(`OFF_STATUS, 32'h7, 32'h1);
    pulse(4'h4);
    woke(1'b1);
    conclude();
  end
endmodule : platform_wake_controller_test
